// *** rtl/vrc_cfg.svh ***
// Register offsets, field positions, reset values and counts for the request controller.
`ifndef VRC_CFG_SVH
`define VRC_CFG_SVH
`define VRC_NUM_REQ         56
`define VRC_IDX_W           6
`define VRC_PRIO_W          4
`define VRC_OFS_FAST_THR    12'h000
`define VRC_OFS_NORM_THR    12'h004
`define VRC_OFS_FAST_VEC    12'h008
`define VRC_OFS_NORM_VEC    12'h00C
`define VRC_OFS_RAW_LO      12'h010
`define VRC_OFS_RAW_HI      12'h014
`define VRC_OFS_REQ_BASE    12'h100
`define VRC_OFS_REQ_LAST    12'h1DC
`define VRC_F_PRIO_LSB      0
`define VRC_F_TARGET        8
`define VRC_F_POL           16
`define VRC_F_SWREQ         24
`define VRC_F_VEC_VALID     31
`define VRC_RST_THR         4'h0
`define VRC_RST_REQ         32'h0000_0000
`endif

// *** rtl/vrc_pkg.sv ***
// Types shared by the request controller files.
package vrc_pkg;
	typedef logic [3:0] vrc_prio_t;
	typedef logic [5:0] vrc_idx_t;
	typedef enum logic [0:0] {
		VRC_TGT_FAST = 1'b0,
		VRC_TGT_NORM = 1'b1
	} vrc_target_t;
endpackage

// *** rtl/vrc_arbiter.sv ***
// Priority arbiter that finds the highest routed request for one target.
`timescale 1ns/1ns
`include "vrc_cfg.svh"
module vrc_arbiter
	import vrc_pkg::*;
(
	input  wire logic [`VRC_NUM_REQ-1:0]             active,
	input  wire logic [`VRC_NUM_REQ-1:0]             routed,
	input  wire logic [`VRC_NUM_REQ*`VRC_PRIO_W-1:0] prio_flat,
	input  wire vrc_prio_t                          threshold,
	output logic                                     hit,
	output vrc_idx_t                                 win_idx
);
	vrc_prio_t best_prio;
	// Lowest index wins a tie so the vector is deterministic.
	always_comb begin
		best_prio = 4'h0;
		win_idx = 6'h00;
		hit = 1'b0;
		for (int i = `VRC_NUM_REQ - 1; i >= 0; i--) begin
			if (active[i] && routed[i] &&
			    prio_flat[i*`VRC_PRIO_W +: `VRC_PRIO_W] != 4'h0 &&
			    prio_flat[i*`VRC_PRIO_W +: `VRC_PRIO_W] > threshold &&
			    prio_flat[i*`VRC_PRIO_W +: `VRC_PRIO_W] >= best_prio) begin
				best_prio = prio_flat[i*`VRC_PRIO_W +: `VRC_PRIO_W];
				win_idx = vrc_idx_t'(i);
				hit = 1'b1;
			end
		end
	end
endmodule

// *** rtl/vrc_top.sv ***
// Vectored request controller with APB registers and two processor lines.
`timescale 1ns/1ns
`include "vrc_cfg.svh"
module vrc_top
	import vrc_pkg::*;
(
	input  wire logic                    controller_branch_clock,
	input  wire logic                    presetn,
	input  wire logic                    clk_en,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic [`VRC_NUM_REQ-1:0] irq_in,
	output logic                         fast_interrupt_line,
	output logic                         normal_interrupt_line
);
	// The branch clock is gated upstream; clk_en freezes state besides.
	wire logic pclk = controller_branch_clock;

	logic [`VRC_NUM_REQ-1:0] sync1_q;
	logic [`VRC_NUM_REQ-1:0] sync2_q;
	logic [`VRC_NUM_REQ-1:0] pol_q;
	logic [`VRC_NUM_REQ-1:0] swreq_q;
	logic [`VRC_NUM_REQ-1:0] target_q;
	logic [`VRC_NUM_REQ*`VRC_PRIO_W-1:0] prio_q;
	vrc_prio_t fast_thr_q;
	vrc_prio_t norm_thr_q;
	logic [`VRC_NUM_REQ-1:0] raw;
	logic [`VRC_NUM_REQ-1:0] routed_fast;
	logic fast_hit;
	logic norm_hit;
	vrc_idx_t fast_idx;
	vrc_idx_t norm_idx;
	logic [31:0] prdata_d;

	wire logic access = psel && penable && clk_en;
	wire logic wr_en = access && pwrite;
	wire logic rd_en = access && !pwrite;
	wire logic in_req = (paddr >= `VRC_OFS_REQ_BASE) && (paddr <= `VRC_OFS_REQ_LAST) &&
	                    (paddr[1:0] == 2'b00);
	wire logic [9:0] req_off = paddr[9:0] - 10'h100;
	wire vrc_idx_t req_idx = vrc_idx_t'(req_off[9:2]);
	wire logic hit_fast_thr = paddr == `VRC_OFS_FAST_THR;
	wire logic hit_norm_thr = paddr == `VRC_OFS_NORM_THR;
	wire logic hit_fast_vec = paddr == `VRC_OFS_FAST_VEC;
	wire logic hit_norm_vec = paddr == `VRC_OFS_NORM_VEC;
	wire logic hit_raw_lo = paddr == `VRC_OFS_RAW_LO;
	wire logic hit_raw_hi = paddr == `VRC_OFS_RAW_HI;
	wire logic mapped = hit_fast_thr || hit_norm_thr || hit_fast_vec || hit_norm_vec ||
	                    hit_raw_lo || hit_raw_hi || in_req;

	// Raw state is the polarity-corrected pin level or the software request.
	assign raw = (sync2_q ^ pol_q) | swreq_q;
	assign routed_fast = ~target_q;

	// Pins are asynchronous to the branch clock, so two stages guard them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 56'h00_0000_0000_0000;
			sync2_q <= 56'h00_0000_0000_0000;
		end else if (clk_en) begin
			sync1_q <= irq_in;
			sync2_q <= sync1_q;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `VRC_NUM_REQ; g++) begin : g_req
			wire logic sel = wr_en && in_req && (req_idx == vrc_idx_t'(g));
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					prio_q[g*`VRC_PRIO_W +: `VRC_PRIO_W] <= `VRC_RST_THR;
					target_q[g] <= 1'b0;
					pol_q[g] <= 1'b0;
					swreq_q[g] <= 1'b0;
				end else if (sel) begin
					prio_q[g*`VRC_PRIO_W +: `VRC_PRIO_W] <=
						pwdata[`VRC_F_PRIO_LSB +: `VRC_PRIO_W];
					target_q[g] <= pwdata[`VRC_F_TARGET];
					pol_q[g] <= pwdata[`VRC_F_POL];
					swreq_q[g] <= pwdata[`VRC_F_SWREQ];
				end
			end
		end
	endgenerate

	vrc_arbiter u_arb_fast (
		.active    (raw),
		.routed    (routed_fast),
		.prio_flat (prio_q),
		.threshold (fast_thr_q),
		.hit       (fast_hit),
		.win_idx   (fast_idx)
	);

	vrc_arbiter u_arb_norm (
		.active    (raw),
		.routed    (target_q),
		.prio_flat (prio_q),
		.threshold (norm_thr_q),
		.hit       (norm_hit),
		.win_idx   (norm_idx)
	);

	wire vrc_idx_t rd_idx = in_req ? req_idx : 6'h00;
	wire logic [31:0] req_word = {7'h00, swreq_q[rd_idx], 7'h00, pol_q[rd_idx],
	                              7'h00, target_q[rd_idx], 4'h0,
	                              prio_q[rd_idx*`VRC_PRIO_W +: `VRC_PRIO_W]};
	wire logic [31:0] fast_vec = {fast_hit, 25'h000_0000, fast_idx};
	wire logic [31:0] norm_vec = {norm_hit, 25'h000_0000, norm_idx};

	always_comb begin
		prdata_d = 32'h0000_0000;
		if (hit_fast_thr) prdata_d = {28'h000_0000, fast_thr_q};
		if (hit_norm_thr) prdata_d = {28'h000_0000, norm_thr_q};
		if (hit_fast_vec) prdata_d = fast_vec;
		if (hit_norm_vec) prdata_d = norm_vec;
		if (hit_raw_lo) prdata_d = raw[31:0];
		if (hit_raw_hi) prdata_d = {8'h00, raw[55:32]};
		if (in_req) prdata_d = req_word;
	end

	// Read data is registered in the setup cycle, so access completes in one cycle when clk_en is high at the setup edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite) prdata <= prdata_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_thr_q <= `VRC_RST_THR;
			norm_thr_q <= `VRC_RST_THR;
		end else if (wr_en) begin
			if (hit_fast_thr) fast_thr_q <= pwdata[3:0];
			if (hit_norm_thr) norm_thr_q <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_interrupt_line <= 1'b0;
			normal_interrupt_line <= 1'b0;
		end else if (clk_en) begin
			fast_interrupt_line <= fast_hit;
			normal_interrupt_line <= norm_hit;
		end
	end

	wire logic unused_rd = rd_en;
endmodule

// *** dv/vrc_assertions.sv ***
// Port-level checks for the request controller.
`timescale 1ns/1ns
module vrc_assertions (
	input wire logic        controller_branch_clock,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [55:0] irq_in,
	input wire logic        fast_interrupt_line,
	input wire logic        normal_interrupt_line
);
	default clocking @(posedge controller_branch_clock); endclocking
	default disable iff (!presetn);
	wire setup  = psel && !penable && clk_en;
	wire wr     = psel && penable && pwrite && pready;
	wire mapped = paddr[1:0] == 2'h0 && (paddr <= 12'h014 || (paddr >= 12'h100 && paddr <= 12'h1DC));
	AST_READY: assert property (setup |=> pready)
		else $error("ready missing after setup");
	AST_ONE: assert property (pready && clk_en |=> !pready) else $error("ready held");
	AST_IDLE: assert property (!psel && clk_en |=> !pready) else $error("ready when idle");
	AST_ERR: assert property (pslverr |-> pready) else $error("error without ready");
	AST_UNMAP: assert property (setup && !mapped |=> pslverr) else $error("no error");
	AST_MAP: assert property (setup && mapped |=> !pslverr) else $error("bad error");
	AST_RST: assert property ($rose(presetn) |-> !fast_interrupt_line && !normal_interrupt_line)
		else $error("line set after reset");
	// A line may only move two edges after a write or three after a pin change.
	AST_FAST: assert property ($changed(fast_interrupt_line) |-> $past(wr, 2) ||
		$past(irq_in, 3) != $past(irq_in, 4)) else $error("fast line moved without cause");
	AST_NORM: assert property ($changed(normal_interrupt_line) |-> $past(wr, 2) ||
		$past(irq_in, 3) != $past(irq_in, 4)) else $error("normal line moved without cause");
endmodule
bind vrc_top vrc_assertions i_vrc_assertions (.controller_branch_clock(controller_branch_clock),
	.presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
	.fast_interrupt_line(fast_interrupt_line), .normal_interrupt_line(normal_interrupt_line));

// *** dv/vrc_core_model.sv ***
// Processor core stand-in that counts entries on its two interrupt inputs.
`timescale 1ns/1ns
module vrc_core_model (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic fast_line,
	input  wire logic normal_line,
	output int        entries
);
	logic fast_q;
	logic norm_q;
	// The core is always ready, so each rising level is one entry.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fast_q <= 1'b0;
			norm_q <= 1'b0;
			entries <= 0;
		end else begin
			fast_q <= fast_line;
			norm_q <= normal_line;
			entries <= entries + int'(fast_line && !fast_q) + int'(normal_line && !norm_q);
		end
	end
endmodule

// *** dv/vectored_interrupt_priority_router_tb.sv ***
// Self-checking bench for the request controller.
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
module vectored_interrupt_priority_router_tb;
	logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, err, fast, norm;
	logic [55:0] irq = '0, raw;
	int          n_errors, total_checks, n, t, b, pr[56], tg[56], po[56], sw[56], thr[2];
	int          ent, rises, pf, pn;
	int unsigned rs = 88352;
	always #20 clk = ~clk;
	vrc_top i_vrc_top (.controller_branch_clock(clk), .presetn(rstn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_in(irq),
		.fast_interrupt_line(fast), .normal_interrupt_line(norm));
	vrc_core_model i_vrc_core_model (.clk(clk), .rstn(rstn), .fast_line(fast),
		.normal_line(norm), .entries(ent));
	function int unsigned rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic end_of_test();
		if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Ready is judged at the rising edge, the same edge at which the write lands.
		@(posedge clk);
		while (pready !== 1'b1 && k < 20) begin
			k++;
			@(posedge clk);
		end
		if (pready !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Highest qualifying priority wins, lowest index on a tie; -1 when none qualifies.
	function automatic int best(int t);
		int b;
		b = -1;
		for (int i = 0; i < 56; i++)
			if (raw[i] && tg[i] == t && pr[i] > thr[t] && (b < 0 || pr[i] > pr[b])) b = i;
		return b;
	endfunction
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, 12'h000, '0);
		`CHK("fast threshold", 32'h0000_0000, rd)
		apb(1'b0, 12'h0FC, '0);
		`CHK("unmapped error", 1'b1, err)
		for (int it = 0; it < 80; it++) begin
			n = rnd() % 56;
			pr[n] = rnd() % 16;
			tg[n] = rnd() % 2;
			po[n] = rnd() % 2;
			sw[n] = rnd() % 4 == 0;
			apb(1'b1, 12'(256 + 4 * n), pr[n] | tg[n] << 8 | po[n] << 16 | sw[n] << 24);
			t = rnd() % 2;
			thr[t] = rnd() % 16;
			apb(1'b1, 12'(4 * t), thr[t]);
			irq <= 56'({rnd(), rnd()});
			repeat (4) @(negedge clk);
			for (int i = 0; i < 56; i++) raw[i] = (irq[i] ^ po[i][0]) | sw[i][0];
			`CHK("fast line", best(0) >= 0, fast)
			`CHK("normal line", best(1) >= 0, norm)
			// Each line that was low at one check and high at the next rose at least once.
			rises += int'(best(0) >= 0 && pf == 0) + int'(best(1) >= 0 && pn == 0);
			pf = int'(best(0) >= 0);
			pn = int'(best(1) >= 0);
			for (t = 0; t < 2; t++) begin
				b = best(t);
				apb(1'b0, 12'(8 + 4 * t), '0);
				`CHK("vector", b < 0 ? 0 : 32'h8000_0000 + b, {rd[31:6], rd[5:0] & {6{rd[31]}}})
			end
			apb(1'b0, 12'h010, '0);
			`CHK("raw low", raw[31:0], rd)
			apb(1'b0, 12'h014, '0);
			`CHK("raw high", {8'h00, raw[55:32]}, rd)
		end
		`CHK("core entries", 1'b1, ent >= rises)
		end_of_test();
	end
endmodule
